// file: design/mvi_irq_ctrl.sv
// Multi-vector interrupt request flags, enables, priority and context save
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "mvi_defines.svh"
// Summary of operation
// - Basic timer overflow always sets its flag
// - Basic timer vectors only when enabled
// - Timer/counter overflow always sets its flag
// - Flag raised while disabled vectors only if its source fires again while enabled
// - Wide timer overflow sets flag; vectors if enabled
// - Conversion done always sets its flag
// - Sync serial completion always sets its flag
// - UART receive/transmit completion set their flags
// - Wake from power-down or green sets flag
// - Pin edge matching selection sets pin flag
// - Each source owns a unique vector address
// - Global enable gates all vectoring; resets to zero
// - Edge select: 01 rise, 10 fall, 11 both
// - Save accumulator/working registers; restore on return
module mvi_irq_ctrl
    import mvi_pkg::*;
#(
    parameter int CTX_BYTES = 17
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output mvi_pkg::mvi_byte_t             reg_rdata,
    // Source events, one-cycle pulses; ext_irq_a and ext_irq_b are pin levels
    input  wire logic                      wakeup_event,
    input  wire logic                      ext_irq_a,
    input  wire logic                      ext_irq_b,
    input  wire logic                      basic_timer_ovf,
    input  wire logic                      timer_counter_a_ovf,
    input  wire logic                      wide_timer_ovf,
    input  wire logic                      conversion_done,
    input  wire logic                      sync_serial_done,
    input  wire logic                      ms_serial_done,
    input  wire logic                      uart_receive_done,
    input  wire logic                      uart_transmit_done,
    // CPU side
    input  wire logic                      cpu_take,
    input  wire logic                      return_from_interrupt,
    input  wire logic [CTX_BYTES*8-1:0]    ctx_in,
    output logic [CTX_BYTES*8-1:0]         ctx_out,
    output logic                           ctx_restore,
    output logic                           vector_req,
    output mvi_pkg::mvi_vec_t              vector_addr,
    output logic                           in_service,
    // Controller event interrupt
    output logic                           irq_out
);
    import mvi_pkg::*;

    typedef struct packed {
        mvi_state_e                 state;
        mvi_src_t                   flag;
        mvi_src_t                   armed;
        mvi_src_t                   en;
        logic                       global_irq_enable;
        logic [3:0]                 edge_cfg;
        logic [CTX_BYTES*8-1:0]     ctx;
        logic                       restore;
        logic                       vreq;
        mvi_vec_t                   vaddr;
        logic [3:0]                 sel;
        logic [`MVI_EV_NUM-1:0]     ev_stat;
        logic [`MVI_EV_NUM-1:0]     ev_en;
        logic                       irq;
        mvi_byte_t                  rdata;
    } mvi_ctrl_s;

    mvi_ctrl_s st_r;
    mvi_ctrl_s st_nxt;

    logic     hit_a;
    logic     hit_b;
    mvi_src_t ev;
    mvi_src_t clr;
    mvi_src_t ready;
    logic     pick_any;
    logic [3:0] pick_idx;

    mvi_edge_detect u_edge_a (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .pin      (ext_irq_a),
        .edge_sel (st_r.edge_cfg[1:0]),
        .hit      (hit_a)
    );

    mvi_edge_detect u_edge_b (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .pin      (ext_irq_b),
        .edge_sel (st_r.edge_cfg[3:2]),
        .hit      (hit_b)
    );

    // Events gathered in vector order
    always_comb begin
        ev                  = '0;
        ev[`MVI_SRC_WAKE]   = wakeup_event;
        ev[`MVI_SRC_EXTA]   = hit_a;
        ev[`MVI_SRC_EXTB]   = hit_b;
        ev[`MVI_SRC_BTIM]   = basic_timer_ovf;
        ev[`MVI_SRC_TCA]    = timer_counter_a_ovf;
        ev[`MVI_SRC_WTIM]   = wide_timer_ovf;
        ev[`MVI_SRC_ADC]    = conversion_done;
        ev[`MVI_SRC_SSP]    = sync_serial_done;
        ev[`MVI_SRC_MSP]    = ms_serial_done;
        ev[`MVI_SRC_URX]    = uart_receive_done;
        ev[`MVI_SRC_UTX]    = uart_transmit_done;
    end

    // A pending request vectors only if armed, enabled, unserviced and globally enabled
    assign ready = st_r.flag & st_r.armed & st_r.en;

    // Lowest index is lowest vector address
    always_comb begin
        pick_any = 1'b0;
        pick_idx = '0;
        for (int i = `MVI_NSRC - 1; i >= 0; i--) begin
            if (ready[i]) begin
                pick_any = 1'b1;
                pick_idx = 4'(i);
            end
        end
    end

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = '0;
        clr          = '0;
        st_nxt.restore = 1'b0;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `MVI_OFF_FLAG_CLR) begin
                clr = mvi_src_t'({reg_wdata[2:0], reg_wdata});
            end else if (reg_addr == `MVI_OFF_ENABLE) begin
                st_nxt.en = mvi_src_t'({reg_wdata[2:0], reg_wdata});
            end else if (reg_addr == `MVI_OFF_CTRL) begin
                st_nxt.global_irq_enable = reg_wdata[`MVI_CTRL_GIE];
            end else if (reg_addr == `MVI_OFF_EDGE) begin
                st_nxt.edge_cfg = reg_wdata[3:0];
            end else if (reg_addr == `MVI_OFF_IRQ_CLR) begin
                st_nxt.ev_stat = st_r.ev_stat & ~reg_wdata[`MVI_EV_NUM-1:0];
            end else if (reg_addr == `MVI_OFF_IRQ_EN) begin
                st_nxt.ev_en = reg_wdata[`MVI_EV_NUM-1:0];
            end
        end
        // Enable and clear registers are written as two halves: low byte, then high bits at the same offset with bit 4 set (plus 10h)
        if (reg_wr && reg_addr == (`MVI_OFF_ENABLE | 8'h10)) begin
            st_nxt.en[10:8] = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == (`MVI_OFF_FLAG_CLR | 8'h10)) begin
            clr = {reg_wdata[2:0], 8'h00};
        end
        if (reg_wr && reg_addr == `MVI_OFF_ENABLE) begin
            st_nxt.en[10:8] = st_r.en[10:8];
        end
        if (reg_wr && reg_addr == `MVI_OFF_FLAG_CLR) begin
            clr[10:8] = 3'b000;
        end

        // Flags set regardless of enable; set wins over clear; no hardware clear
        st_nxt.flag = (st_r.flag & ~clr) | ev;
        // A flag raised while disabled stays disarmed until cleared or until its source fires again while enabled
        for (int i = 0; i < `MVI_NSRC; i++) begin
            if (ev[i]) begin
                st_nxt.armed[i] = st_r.en[i] | (st_r.flag[i] & st_r.armed[i]);
            end else if (clr[i]) begin
                st_nxt.armed[i] = 1'b1;
            end
        end

        st_nxt.vreq = 1'b0;
        case (st_r.state)
            MVI_IDLE: begin
                if (pick_any && st_r.global_irq_enable) begin
                    st_nxt.vaddr = `MVI_VEC_BASE + mvi_vec_t'(pick_idx)
                                 + ((pick_idx >= 4'(`MVI_VEC_GAP_AT)) ? `MVI_VEC_GAP_LEN : 8'h00);
                    // Remember the chosen source; later events must not change what is disarmed
                    st_nxt.sel   = pick_idx;
                    st_nxt.vreq  = 1'b1;
                    st_nxt.state = MVI_SAVE;
                end
            end
            MVI_SAVE: begin
                st_nxt.vreq = 1'b1;
                if (cpu_take) begin
                    st_nxt.vreq  = 1'b0;
                    st_nxt.ctx   = ctx_in;
                    st_nxt.armed[st_r.sel] = 1'b0;
                    st_nxt.ev_stat[`MVI_EV_VECTOR] = 1'b1;
                    st_nxt.state = MVI_BUSY;
                end
            end
            MVI_BUSY: begin
                if (return_from_interrupt) begin
                    st_nxt.restore = 1'b1;
                    st_nxt.ev_stat[`MVI_EV_RETURN] = 1'b1;
                    st_nxt.state = MVI_IDLE;
                end
            end
            default: st_nxt.state = MVI_IDLE;
        endcase

        st_nxt.irq = |(st_nxt.ev_stat & st_nxt.ev_en);

        // Register reads, data in the next cycle
        if (reg_rd) begin
            if (reg_addr == `MVI_OFF_FLAG) begin
                st_nxt.rdata = st_r.flag[7:0];
            end else if (reg_addr == (`MVI_OFF_FLAG | 8'h10)) begin
                st_nxt.rdata = {5'b0_0000, st_r.flag[10:8]};
            end else if (reg_addr == `MVI_OFF_ENABLE) begin
                st_nxt.rdata = st_r.en[7:0];
            end else if (reg_addr == (`MVI_OFF_ENABLE | 8'h10)) begin
                st_nxt.rdata = {5'b0_0000, st_r.en[10:8]};
            end else if (reg_addr == `MVI_OFF_CTRL) begin
                st_nxt.rdata = {7'b000_0000, st_r.global_irq_enable};
            end else if (reg_addr == `MVI_OFF_EDGE) begin
                st_nxt.rdata = {4'h0, st_r.edge_cfg};
            end else if (reg_addr == `MVI_OFF_VECTOR) begin
                st_nxt.rdata = st_r.vaddr;
            end else if (reg_addr == `MVI_OFF_IRQ_STAT) begin
                st_nxt.rdata = {6'b00_0000, st_r.ev_stat};
            end else if (reg_addr == `MVI_OFF_IRQ_EN) begin
                st_nxt.rdata = {6'b00_0000, st_r.ev_en};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_r          <= '0;
            st_r.state    <= MVI_IDLE;
            st_r.armed    <= '1;
            st_r.global_irq_enable      <= `MVI_CTRL_GIE_RST;
            st_r.edge_cfg <= `MVI_EDGE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata   = st_r.rdata;
    assign ctx_out     = st_r.ctx;
    assign ctx_restore = st_r.restore;
    assign vector_req  = st_r.vreq;
    assign vector_addr = st_r.vaddr;
    assign in_service  = st_r.state[2];
    assign irq_out     = st_r.irq;
endmodule

// file: design/mvi_defines.svh
// Offsets, field positions, reset values and vector addresses of the interrupt request block
`ifndef MVI_DEFINES_SVH
`define MVI_DEFINES_SVH

`define MVI_NSRC          11
`define MVI_VEC_W         8
// Register offsets
`define MVI_OFF_FLAG      8'h00
`define MVI_OFF_FLAG_CLR  8'h01
`define MVI_OFF_ENABLE    8'h02
`define MVI_OFF_CTRL      8'h03
`define MVI_OFF_EDGE      8'h04
`define MVI_OFF_VECTOR    8'h05
`define MVI_OFF_IRQ_STAT  8'h06
`define MVI_OFF_IRQ_CLR   8'h07
`define MVI_OFF_IRQ_EN    8'h08
// Source positions, in vector order
`define MVI_SRC_WAKE      0
`define MVI_SRC_EXTA      1
`define MVI_SRC_EXTB      2
`define MVI_SRC_BTIM      3
`define MVI_SRC_TCA       4
`define MVI_SRC_WTIM      5
`define MVI_SRC_ADC       6
`define MVI_SRC_SSP       7
`define MVI_SRC_MSP       8
`define MVI_SRC_URX       9
`define MVI_SRC_UTX       10
// First vector; source n vectors to base plus n, with two spare words at 0DH and 0EH
`define MVI_VEC_BASE      8'h08
`define MVI_VEC_GAP_AT    5
`define MVI_VEC_GAP_LEN   8'h02
// Control register bits
`define MVI_CTRL_GIE      0
`define MVI_CTRL_GIE_RST  1'b0
// Edge select encodings and reset value
`define MVI_EDGE_RISE     2'b01
`define MVI_EDGE_FALL     2'b10
`define MVI_EDGE_BOTH     2'b11
`define MVI_EDGE_RST      4'b1010
// Controller status events
`define MVI_EV_VECTOR     0
`define MVI_EV_RETURN     1
`define MVI_EV_NUM        2

`endif

// file: design/mvi_pkg.sv
// Types for the interrupt request block
package mvi_pkg;
    typedef logic [10:0] mvi_src_t;
    typedef logic [7:0]  mvi_byte_t;
    typedef logic [7:0]  mvi_vec_t;

    typedef enum logic [2:0] {
        MVI_IDLE = 3'b001,
        MVI_SAVE = 3'b010,
        MVI_BUSY = 3'b100
    } mvi_state_e;
endpackage

// file: design/mvi_edge_detect.sv
// Edge detector for one external interrupt pin
`timescale 1ns/1ps
`include "mvi_defines.svh"
module mvi_edge_detect (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Pin and edge selection
    input  wire logic       pin,
    input  wire logic [1:0] edge_sel,
    // Matching edge seen
    output logic            hit
);
    typedef struct packed {
        logic prev;
        logic hit;
        logic live;
    } mvi_edge_s;

    mvi_edge_s st_r;
    mvi_edge_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = pin;
        // Reserved selection 00 never fires
        case (edge_sel)
            `MVI_EDGE_RISE: st_nxt.hit = pin & ~st_r.prev;
            `MVI_EDGE_FALL: st_nxt.hit = ~pin & st_r.prev;
            `MVI_EDGE_BOTH: st_nxt.hit = pin ^ st_r.prev;
            default:        st_nxt.hit = 1'b0;
        endcase
        // First cycle after reset only primes prev, so an idle-high pin gives no false edge
        st_nxt.live = 1'b1;
        if (!st_r.live) begin
            st_nxt.hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hit = st_r.hit;
endmodule

// file: bench/mvi_irq_ctrl_sva.sv
// Port-level assertions for the interrupt request block
`timescale 1ns/1ps
`include "mvi_defines.svh"
module mvi_irq_ctrl_sva
    import mvi_pkg::*;
#(
    parameter int CTX_BYTES = 17
) (
    // Clock and reset
    input wire logic                   ref_clk,
    input wire logic                   reset_n,
    // Register port
    input wire logic [7:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire mvi_pkg::mvi_byte_t     reg_rdata,
    // CPU side
    input wire logic                   cpu_take,
    input wire logic                   return_from_interrupt,
    input wire logic [CTX_BYTES*8-1:0] ctx_in,
    input wire logic [CTX_BYTES*8-1:0] ctx_out,
    input wire logic                   ctx_restore,
    input wire logic                   vector_req,
    input wire mvi_pkg::mvi_vec_t      vector_addr,
    input wire logic                   in_service,
    input wire logic                   irq_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Shadow of the global enable, followed from register writes
    logic gie_r;
    logic gie_nxt;
    always_comb begin
        gie_nxt = gie_r;
        if (reg_wr && reg_addr == `MVI_OFF_CTRL) begin
            gie_nxt = reg_wdata[`MVI_CTRL_GIE];
        end
    end
    always_ff @(posedge ref_clk) begin
        gie_r <= reset_n ? gie_nxt : 1'b0;
    end
    a_gie_gates_vec: assert property ($rose(vector_req) |-> $past(gie_r))
        else $error("vector raised with global enable off");
    a_vec_addr_legal: assert property (vector_req |-> vector_addr inside {[8'h08:8'h0C], [8'h0F:8'h14]})
        else $error("vector address outside the table");
    a_vec_held: assert property (vector_req && !cpu_take |=> vector_req && $stable(vector_addr))
        else $error("vector request dropped or changed before take");
    a_take_saves_ctx: assert property (vector_req && cpu_take |=> !vector_req && in_service && ctx_out == $past(ctx_in))
        else $error("take did not save context or enter service");
    a_svc_no_vec: assert property (in_service && !return_from_interrupt |=> in_service && !vector_req)
        else $error("service left or new vector while in service");
    a_return_restores: assert property (in_service && return_from_interrupt |=> ctx_restore && !in_service ##1 !ctx_restore)
        else $error("return did not restore context for one cycle");
    a_restore_cause: assert property (ctx_restore |-> $past(return_from_interrupt) && $past(in_service))
        else $error("restore without a return in service");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    c_take: cover property (vector_req && cpu_take);
    c_restore: cover property (ctx_restore);
    c_last_vec: cover property ($rose(vector_req) && vector_addr == 8'h14);
endmodule

bind mvi_irq_ctrl mvi_irq_ctrl_sva #(.CTX_BYTES(CTX_BYTES)) mvi_irq_ctrl_sva_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_take(cpu_take), .return_from_interrupt(return_from_interrupt),
    .ctx_in(ctx_in), .ctx_out(ctx_out), .ctx_restore(ctx_restore), .vector_req(vector_req),
    .vector_addr(vector_addr), .in_service(in_service), .irq_out(irq_out)
);

// file: bench/tb.sv
// Self-checking bench for the interrupt request block
`timescale 1ns/1ps
`include "mvi_defines.svh"
module tb;
    import mvi_pkg::*;
    logic         ref_clk, reset_n, reg_wr, reg_rd, pin_a, pin_b, cpu_take, rfi;
    logic [7:0]   reg_addr, reg_wdata;
    logic [10:0]  ev;
    logic [135:0] ctx_in, ctx_out;
    mvi_byte_t    reg_rdata;
    mvi_vec_t     vector_addr;
    logic         ctx_restore, vector_req, in_service, irq_out;
    int           num_errors, cmp_count;

    mvi_irq_ctrl mvi_irq_ctrl_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wakeup_event(ev[0]), .ext_irq_a(pin_a), .ext_irq_b(pin_b),
        .basic_timer_ovf(ev[3]), .timer_counter_a_ovf(ev[4]), .wide_timer_ovf(ev[5]), .conversion_done(ev[6]),
        .sync_serial_done(ev[7]), .ms_serial_done(ev[8]), .uart_receive_done(ev[9]), .uart_transmit_done(ev[10]),
        .cpu_take(cpu_take), .return_from_interrupt(rfi), .ctx_in(ctx_in), .ctx_out(ctx_out),
        .ctx_restore(ctx_restore), .vector_req(vector_req), .vector_addr(vector_addr), .in_service(in_service),
        .irq_out(irq_out)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [135:0] seen, input logic [135:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask

    // Source 1 and 2 are pins and toggle; the rest pulse for one cycle
    task automatic pulse(input int i);
        @(posedge ref_clk);
        if (i == 1) pin_a <= ~pin_a;
        else if (i == 2) pin_b <= ~pin_b;
        else ev <= 11'(1) << i;
        @(posedge ref_clk);
        ev <= '0;
        @(posedge ref_clk);
    endtask

    function automatic logic [7:0] vec_of(input int i);
        return 8'(i) + ((i < 5) ? 8'h08 : 8'h0A);
    endfunction

    task automatic service(input logic [7:0] vec);
        int n;
        #1;
        for (n = 0; n < 20 && vector_req !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (vector_req !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
        check(vector_addr, vec);
        @(posedge ref_clk);
        cpu_take <= 1'b1;
        ctx_in <= {17{vec}};
        @(posedge ref_clk);
        cpu_take <= 1'b0;
        #1 check(ctx_out, {17{vec}});
        check(in_service, 1'b1);
        @(posedge ref_clk);
        rfi <= 1'b1;
        @(posedge ref_clk);
        rfi <= 1'b0;
        #1 check(ctx_restore, 1'b1);
    endtask

    task automatic t_reset_and_flags();
        rd(`MVI_OFF_CTRL, 8'h00);
        rd(`MVI_OFF_EDGE, 8'h0A);
        rd(8'h3F, 8'h00);
        for (int i = 0; i < 11; i++) if (i != 1 && i != 2) pulse(i);
        rd(`MVI_OFF_FLAG, 8'hF9);
        rd(`MVI_OFF_FLAG | 8'h10, 8'h07);
        wr(`MVI_OFF_FLAG_CLR | 8'h10, 8'h07);
        rd(`MVI_OFF_FLAG | 8'h10, 8'h00);
    endtask

    task automatic t_edges();
        for (int m = 0; m < 4; m++) begin
            wr(`MVI_OFF_EDGE, 8'(m * 5));
            wr(`MVI_OFF_FLAG_CLR, 8'hFF);
            pulse(1);
            pulse(2);
            rd(`MVI_OFF_FLAG, m[0] ? 8'h06 : 8'h00);
            wr(`MVI_OFF_FLAG_CLR, 8'h06);
            pulse(1);
            pulse(2);
            rd(`MVI_OFF_FLAG, m[1] ? 8'h06 : 8'h00);
        end
        wr(`MVI_OFF_FLAG_CLR, 8'hFF);
    endtask

    task automatic t_gating();
        pulse(4);
        wr(`MVI_OFF_ENABLE, 8'h18);
        pulse(3);
        repeat (4) @(posedge ref_clk);
        #1 check(vector_req, 1'b0);
        wr(`MVI_OFF_IRQ_EN, 8'h01);
        rd(`MVI_OFF_IRQ_EN, 8'h01);
        rd(`MVI_OFF_ENABLE, 8'h18);
        wr(`MVI_OFF_CTRL, 8'h01);
        service(8'h0B);
        wr(`MVI_OFF_FLAG_CLR, 8'h08);
        repeat (4) @(posedge ref_clk);
        #1 check(vector_req, 1'b0);
        check(irq_out, 1'b1);
        rd(`MVI_OFF_IRQ_STAT, 8'h03);
        wr(`MVI_OFF_IRQ_CLR, 8'h03);
        repeat (2) @(posedge ref_clk);
        #1 check(irq_out, 1'b0);
        wr(`MVI_OFF_FLAG_CLR, 8'h10);
        pulse(4);
        service(8'h0C);
        rd(`MVI_OFF_FLAG, 8'h10);
        repeat (4) @(posedge ref_clk);
        #1 check(vector_req, 1'b0);
        wr(`MVI_OFF_FLAG_CLR, 8'h10);
    endtask

    task automatic t_vectors();
        wr(`MVI_OFF_ENABLE, 8'hFF);
        wr(`MVI_OFF_ENABLE | 8'h10, 8'h07);
        rd(`MVI_OFF_ENABLE | 8'h10, 8'h07);
        for (int i = 0; i < 11; i++) begin
            pulse(i);
            service(vec_of(i));
            if (i < 8) wr(`MVI_OFF_FLAG_CLR, 8'(1 << i));
            else wr(`MVI_OFF_FLAG_CLR | 8'h10, 8'(1 << (i - 8)));
        end
        @(posedge ref_clk);
        ev <= 11'h408;
        @(posedge ref_clk);
        ev <= '0;
        rd(`MVI_OFF_FLAG | 8'h10, 8'h04);
        service(8'h0B);
        wr(`MVI_OFF_FLAG_CLR, 8'h08);
        service(8'h14);
        rd(`MVI_OFF_VECTOR, 8'h14);
        wr(`MVI_OFF_FLAG_CLR | 8'h10, 8'h04);
        wr(`MVI_OFF_ENABLE, 8'h00);
        pulse(3);
        repeat (4) @(posedge ref_clk);
        #1 check(vector_req, 1'b0);
    endtask

    initial begin
        {reset_n, reg_wr, reg_rd, pin_a, pin_b, cpu_take, rfi} = '0;
        {reg_addr, reg_wdata, ev, ctx_in} = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset_and_flags();
        t_edges();
        t_gating();
        t_vectors();
        tally_and_finish();
    end
endmodule
